// ===== rtl/siu_defs.vh
// Constants for the supervisor instruction unit
`ifndef SIU_DEFS_VH
`define SIU_DEFS_VH

// Primary opcodes and extended opcodes
`define SIU_OP_SC       6'h11
`define SIU_OP_XL       6'h13
`define SIU_OP_X        6'h1F
`define SIU_XO_RFI      10'h032
`define SIU_XO_MFMSR    10'h053
`define SIU_XO_MTMSR    10'h092
`define SIU_XO_MFSPR    10'h153
`define SIU_XO_MTSPR    10'h1D3
`define SIU_XO_DCBI     10'h1D6
`define SIU_XO_MTSR     10'h0D2
`define SIU_XO_MTSRIN   10'h0F2
`define SIU_XO_MFSR     10'h253
`define SIU_XO_MFSRIN   10'h293

// Special register numbers
`define SIU_SPR_SAVEPC  10'h01A
`define SIU_SPR_SAVEST  10'h01B
`define SIU_SPR_TBLO    10'h11C
`define SIU_SPR_TBHI    10'h11D

// Machine state bit positions (little-endian index)
`define SIU_MSR_POW     18
`define SIU_MSR_EE      15
`define SIU_MSR_PR      14
`define SIU_MSR_IP      6
`define SIU_MSR_DR      4
`define SIU_MSR_LE      0

// Machine state masks
`define SIU_MSR_COPY    32'h0000FF73
`define SIU_SAVE_CLR    32'h783F0000
`define SIU_MSR_EXCCLR  32'h0000C030
`define SIU_MSR_NOSYNC  32'h00040001
`define SIU_MSR_RST     32'h00000040

// Vector offsets
`define SIU_VEC_SYS     32'h00000100
`define SIU_VEC_DSI     32'h00000300
`define SIU_VEC_EXT     32'h00000500
`define SIU_VEC_PROG    32'h00000700
`define SIU_VEC_SC      32'h00000C00

// Exception codes
`define SIU_EXC_NONE    3'h0
`define SIU_EXC_SC      3'h1
`define SIU_EXC_PROG    3'h2
`define SIU_EXC_DSI     3'h3
`define SIU_EXC_EXT     3'h4
`define SIU_EXC_SYS     3'h5

// Register port map
`define SIU_REG_CTL     4'h0
`define SIU_REG_MSR     4'h1
`define SIU_REG_SPC     4'h2
`define SIU_REG_SST     4'h3
`define SIU_REG_STAT    4'h4

`define SIU_ZERO32      32'h00000000
`define SIU_PC_STEP     32'h00000004

`endif

// ===== rtl/siu_supervisor_unit.v
// Supervisor instruction execution: linkage, state, special and segment moves, block invalidate
//
// Operation
// - System call saves next address, raises exception
// - System call clears save state bits 1-4,10-15
// - System call copies state bits into save state
// - System call vector is base plus C00
// - System call is context synchronizing
// - Return restores state bits; privileged, synchronizing
// - No pending exception: resume at saved address
// - Pending enabled: take it, save next address
// - Wide mode: return invokes system handler
// - State moves privileged; write synchronizes mostly
// - Special moves copy; timebase halves independent
// - Special number rebuilt from swapped halves
// - Cache op in direct-store segment: no-op
// - Address is base-or-zero plus index
// - Coherent invalidate reaches all caches
// - Noncoherent invalidate local only
// - Translation on and missing: data exception
// - Invalidate checked as store, change optional
// - Direct segment moves, privileged
// - Indirect segment moves use index bits 0-3
// - Segment moves ignore translation enables
`timescale 1ns/1ps
`default_nettype none
`include "siu_defs.vh"

module siu_supervisor_unit #(
    parameter [31:0] VEC_BASE_LO = 32'h00000000,  // Base with select bit low
    parameter [31:0] VEC_BASE_HI = 32'hFFF00000   // Base with select bit high
) (
    // Clock and reset
    input  wire        clk,
    input  wire        rst_n,
    // Instruction issue
    input  wire        instrValid,
    input  wire [31:0] instrWord,
    input  wire [31:0] instrPc,
    input  wire [31:0] sourceGpr,
    input  wire [31:0] baseGpr,
    input  wire [31:0] indexGpr,
    // Pending interrupt level
    input  wire        extPending,
    // Translation lookup for block invalidate
    output wire [31:0] mmuAddr,
    output wire        mmuIsStore,
    output wire        mmuSetChange,
    input  wire        mmuMiss,
    input  wire        mmuProtFault,
    input  wire        mmuDirectStore,
    input  wire [2:0]  storageAttrBits,
    // Destination register write
    output reg         gprWe_r,
    output reg  [4:0]  gprSel_r,
    output reg  [31:0] gprData_r,
    // Fetch redirect and exceptions
    output reg         redirValid_r,
    output reg  [31:0] redirAddr_r,
    output reg  [2:0]  excCode_r,
    output reg         ctxSync_r,
    // Cache invalidate request
    output reg         cinvValid_r,
    output reg  [31:0] cinvAddr_r,
    output reg         cinvGlobal_r,
    // Current state
    output wire [31:0] machineState,
    // Register port
    input  wire [3:0]  regAddr,
    input  wire [31:0] regWdata,
    input  wire        regWr,
    input  wire        regRd,
    output reg  [31:0] regRdata_r
);

    // Field extraction
    wire [5:0]  opcode   = instrWord[31:26];
    wire [9:0]  xo       = instrWord[10:1];
    wire [4:0]  dstField = instrWord[25:21];
    wire [4:0]  baseFld  = instrWord[20:16];
    wire [3:0]  segDirect = instrWord[19:16];
    wire [3:0]  segIndir  = indexGpr[31:28];
    wire [9:0]  sprNum   = {instrWord[15:11], instrWord[20:16]};

    // Architected state
    reg  [31:0] msr_r;          // Machine state
    reg  [31:0] savePc_r;       // Save program counter
    reg  [31:0] saveSt_r;       // Save state
    reg  [63:0] tb_r;           // Timebase
    reg  [31:0] seg_r [0:15];   // Segment registers
    reg         wide64_r;       // Wide mode control
    reg  [2:0]  lastExc_r;      // Last exception taken

    assign machineState = msr_r;

    // Decoded instruction kinds
    wire isX     = opcode == `SIU_OP_X;
    wire isSc    = instrValid & (opcode == `SIU_OP_SC);
    wire isRfi   = instrValid & (opcode == `SIU_OP_XL) & (xo == `SIU_XO_RFI);
    wire isMfmsr = instrValid & isX & (xo == `SIU_XO_MFMSR);
    wire isMtmsr = instrValid & isX & (xo == `SIU_XO_MTMSR);
    wire isMfspr = instrValid & isX & (xo == `SIU_XO_MFSPR);
    wire isMtspr = instrValid & isX & (xo == `SIU_XO_MTSPR);
    wire isDcbi  = instrValid & isX & (xo == `SIU_XO_DCBI);
    wire isMtsr  = instrValid & isX & ((xo == `SIU_XO_MTSR) | (xo == `SIU_XO_MTSRIN));
    wire isMfsr  = instrValid & isX & ((xo == `SIU_XO_MFSR) | (xo == `SIU_XO_MFSRIN));
    wire segInd  = (xo == `SIU_XO_MTSRIN) | (xo == `SIU_XO_MFSRIN);
    wire [3:0] segSel = segInd ? segIndir : segDirect;

    // Everything here except the call itself needs supervisor level
    wire isPriv  = isRfi | isMfmsr | isMtmsr | isMfspr | isMtspr | isDcbi | isMtsr | isMfsr;
    wire privErr = isPriv & msr_r[`SIU_MSR_PR];

    // Invalidate address, base field zero means literal zero
    wire [31:0] baseVal = (baseFld == 5'h00) ? `SIU_ZERO32 : baseGpr;
    assign mmuAddr      = baseVal + indexGpr;
    assign mmuIsStore   = isDcbi;
    assign mmuSetChange = 1'b0;                            // change bit not recorded

    // Restored state on return
    wire [31:0] rfiMsr = (msr_r & ~`SIU_MSR_COPY) | (saveSt_r & `SIU_MSR_COPY);
    wire [31:0] rfiPc  = {savePc_r[31:2], 2'b00};
    wire [31:0] nextPc = instrPc + `SIU_PC_STEP;

    // Save state image for an exception taken from state st
    function [31:0] saveImage;
        input [31:0] old;
        input [31:0] st;
        begin
            saveImage = (old & ~(`SIU_SAVE_CLR | `SIU_MSR_COPY)) | (st & `SIU_MSR_COPY);
        end
    endfunction

    // Vector base picked by the select bit
    function [31:0] vecBase;
        input ip;
        begin
            vecBase = ip ? VEC_BASE_HI : VEC_BASE_LO;
        end
    endfunction

    // Special register read mux; unknown numbers read as zero
    reg [31:0] sprRd;
    always @*
    begin
        case (sprNum)
            `SIU_SPR_SAVEPC: sprRd = savePc_r;
            `SIU_SPR_SAVEST: sprRd = saveSt_r;
            `SIU_SPR_TBLO:   sprRd = tb_r[31:0];
            `SIU_SPR_TBHI:   sprRd = tb_r[63:32];
            default:         sprRd = `SIU_ZERO32;
        endcase
    end

    // Execution and architected state
    integer i;
    always @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            msr_r        <= `SIU_MSR_RST;
            savePc_r     <= `SIU_ZERO32;
            saveSt_r     <= `SIU_ZERO32;
            tb_r         <= 64'h0000000000000000;
            wide64_r     <= 1'b0;
            lastExc_r    <= `SIU_EXC_NONE;
            gprWe_r      <= 1'b0;
            gprSel_r     <= 5'h00;
            gprData_r    <= `SIU_ZERO32;
            redirValid_r <= 1'b0;
            redirAddr_r  <= `SIU_ZERO32;
            excCode_r    <= `SIU_EXC_NONE;
            ctxSync_r    <= 1'b0;
            cinvValid_r  <= 1'b0;
            cinvAddr_r   <= `SIU_ZERO32;
            cinvGlobal_r <= 1'b0;
            for (i = 0; i < 16; i = i + 1)
                seg_r[i] <= `SIU_ZERO32;
        end
        else
        begin
            // Pulses default low
            gprWe_r      <= 1'b0;
            redirValid_r <= 1'b0;
            excCode_r    <= `SIU_EXC_NONE;
            ctxSync_r    <= 1'b0;
            cinvValid_r  <= 1'b0;
            gprSel_r     <= dstField;
            // Free-running timebase, overridden by a write below
            tb_r <= tb_r + 64'h0000000000000001;
            // Control register write from the register port
            if (regWr && regAddr == `SIU_REG_CTL)
                wide64_r <= regWdata[0];

            if (privErr)
            begin
                // Privileged attempt at user level: nothing else happens
                savePc_r     <= instrPc;
                saveSt_r     <= saveImage(saveSt_r, msr_r);
                msr_r        <= msr_r & ~`SIU_MSR_EXCCLR;
                redirValid_r <= 1'b1;
                redirAddr_r  <= vecBase(msr_r[`SIU_MSR_IP]) + `SIU_VEC_PROG;
                excCode_r    <= `SIU_EXC_PROG;
                lastExc_r    <= `SIU_EXC_PROG;
                ctxSync_r    <= 1'b1;
            end
            else if (isSc)
            begin
                savePc_r     <= nextPc;
                saveSt_r     <= saveImage(saveSt_r, msr_r);
                msr_r        <= msr_r & ~`SIU_MSR_EXCCLR;
                redirValid_r <= 1'b1;
                // Select bit is not altered on entry, so old equals new
                redirAddr_r  <= vecBase(msr_r[`SIU_MSR_IP]) + `SIU_VEC_SC;
                excCode_r    <= `SIU_EXC_SC;
                lastExc_r    <= `SIU_EXC_SC;
                ctxSync_r    <= 1'b1;
            end
            else if (isRfi)
            begin
                ctxSync_r    <= 1'b1;
                redirValid_r <= 1'b1;
                if (wide64_r)
                begin
                    // Return is undefined in wide mode
                    savePc_r    <= instrPc;
                    saveSt_r    <= saveImage(saveSt_r, msr_r);
                    msr_r       <= msr_r & ~`SIU_MSR_EXCCLR;
                    redirAddr_r <= vecBase(msr_r[`SIU_MSR_IP]) + `SIU_VEC_SYS;
                    excCode_r   <= `SIU_EXC_SYS;
                    lastExc_r   <= `SIU_EXC_SYS;
                end
                else if (rfiMsr[`SIU_MSR_EE] && extPending)
                begin
                    // Enabled pending interrupt taken before the target runs
                    savePc_r    <= rfiPc;
                    saveSt_r    <= saveImage(saveSt_r, rfiMsr);
                    msr_r       <= rfiMsr & ~`SIU_MSR_EXCCLR;
                    redirAddr_r <= vecBase(rfiMsr[`SIU_MSR_IP]) + `SIU_VEC_EXT;
                    excCode_r   <= `SIU_EXC_EXT;
                    lastExc_r   <= `SIU_EXC_EXT;
                end
                else
                begin
                    msr_r       <= rfiMsr;
                    redirAddr_r <= rfiPc;
                end
            end
            else if (isMtmsr)
            begin
                msr_r     <= sourceGpr;
                // Sleep and byte order changes alone do not synchronize
                ctxSync_r <= |((sourceGpr ^ msr_r) & ~`SIU_MSR_NOSYNC);
            end
            else if (isMfmsr)
            begin
                gprWe_r   <= 1'b1;
                gprData_r <= msr_r;
            end
            else if (isMtspr)
            begin
                // Timebase halves are separate; the other half holds its value, not incremented, that cycle
                case (sprNum)
                    `SIU_SPR_SAVEPC: savePc_r <= sourceGpr;
                    `SIU_SPR_SAVEST: saveSt_r <= sourceGpr;
                    `SIU_SPR_TBLO:   tb_r     <= {tb_r[63:32], sourceGpr};
                    `SIU_SPR_TBHI:   tb_r     <= {sourceGpr, tb_r[31:0]};
                    default:         ;
                endcase
            end
            else if (isMfspr)
            begin
                gprWe_r   <= 1'b1;
                gprData_r <= sprRd;
            end
            else if (isMtsr)
            begin
                // Translation enables play no part here
                seg_r[segSel] <= sourceGpr;
            end
            else if (isMfsr)
            begin
                gprWe_r   <= 1'b1;
                gprData_r <= seg_r[segSel];
            end
            else if (isDcbi)
            begin
                if (mmuDirectStore)
                begin
                    // Direct-store segment: the instruction completes doing nothing
                end
                else if ((msr_r[`SIU_MSR_DR] && mmuMiss) || mmuProtFault)
                begin
                    savePc_r     <= instrPc;
                    saveSt_r     <= saveImage(saveSt_r, msr_r);
                    msr_r        <= msr_r & ~`SIU_MSR_EXCCLR;
                    redirValid_r <= 1'b1;
                    redirAddr_r  <= vecBase(msr_r[`SIU_MSR_IP]) + `SIU_VEC_DSI;
                    excCode_r    <= `SIU_EXC_DSI;
                    lastExc_r    <= `SIU_EXC_DSI;
                end
                else
                begin
                    // Modified data is dropped; the cache side never writes back
                    cinvValid_r  <= 1'b1;
                    cinvAddr_r   <= mmuAddr;
                    cinvGlobal_r <= storageAttrBits[0];
                end
            end
        end
    end

    // Register port read, data one cycle after the strobe
    always @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            regRdata_r <= `SIU_ZERO32;
        else if (regRd)
        begin
            case (regAddr)
                `SIU_REG_CTL:  regRdata_r <= {31'h0, wide64_r};
                `SIU_REG_MSR:  regRdata_r <= msr_r;
                `SIU_REG_SPC:  regRdata_r <= savePc_r;
                `SIU_REG_SST:  regRdata_r <= saveSt_r;
                `SIU_REG_STAT: regRdata_r <= {29'h0, lastExc_r};
                default:       regRdata_r <= `SIU_ZERO32;
            endcase
        end
        else
            regRdata_r <= `SIU_ZERO32;
    end

endmodule // siu_supervisor_unit
`default_nettype wire

// ===== tb/siu_supervisor_props.sv
// Concurrent checks on the supervisor unit ports
`timescale 1ns/1ps
`default_nettype none
`include "siu_defs.vh"
module siu_supervisor_props #(
    parameter [31:0] VEC_BASE_LO = 32'h00000000,  // Base, select low
    parameter [31:0] VEC_BASE_HI = 32'hFFF00000   // Base, select high
) (
    // Clock, reset and issue
    input wire        clk,
    input wire        rst_n,
    input wire        instrValid,
    input wire [31:0] instrWord,
    input wire [31:0] sourceGpr,
    input wire [31:0] baseGpr,
    input wire [31:0] indexGpr,
    // Translation side
    input wire [31:0] mmuAddr,
    input wire        mmuIsStore,
    input wire        mmuMiss,
    input wire        mmuProtFault,
    input wire        mmuDirectStore,
    input wire [2:0]  storageAttrBits,
    // Results
    input wire        gprWe_r,
    input wire [31:0] gprData_r,
    input wire [31:0] redirAddr_r,
    input wire [2:0]  excCode_r,
    input wire        ctxSync_r,
    input wire        cinvValid_r,
    input wire [31:0] cinvAddr_r,
    input wire        cinvGlobal_r,
    input wire [31:0] machineState
);
    wire [9:0]  xo  = instrWord[10:1];                            // Extended opcode
    wire        isX = instrValid && instrWord[31:26] == `SIU_OP_X; // Indexed form
    wire        sup = !machineState[`SIU_MSR_PR];                 // Supervisor level
    wire        inv = isX && xo == `SIU_XO_DCBI && sup;           // Invalidate taken
    wire [31:0] vb  = machineState[`SIU_MSR_IP] ? VEC_BASE_HI : VEC_BASE_LO;
    wire [31:0] ea  = (instrWord[20:16] == 5'h00 ? 32'h0 : baseGpr) + indexGpr;
    // Every supervisor-only opcode of this unit
    wire priv = (instrValid && instrWord[31:26] == `SIU_OP_XL && xo == `SIU_XO_RFI) || (isX && (xo == `SIU_XO_MFMSR
        || xo == `SIU_XO_MTMSR || xo == `SIU_XO_MFSPR || xo == `SIU_XO_MTSPR || xo == `SIU_XO_DCBI
        || xo == `SIU_XO_MTSR || xo == `SIU_XO_MTSRIN || xo == `SIU_XO_MFSR || xo == `SIU_XO_MFSRIN));

    // One domain only
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    chk_sc_entry: assert property (instrValid && instrWord[31:26] == `SIU_OP_SC |=> excCode_r == `SIU_EXC_SC
        && ctxSync_r && redirAddr_r == vb + `SIU_VEC_SC) else $error("system call entry wrong");
    chk_priv_trap: assert property (priv && !sup |=> excCode_r == `SIU_EXC_PROG && !gprWe_r && !cinvValid_r
        && redirAddr_r == vb + `SIU_VEC_PROG) else $error("user level op not trapped");
    chk_ea_form: assert property (inv |-> mmuAddr == ea && mmuIsStore) else $error("invalidate address wrong");
    chk_inv_scope: assert property (inv && !mmuDirectStore && !mmuProtFault
        && !(machineState[`SIU_MSR_DR] && mmuMiss) |=> cinvValid_r && cinvAddr_r == $past(ea)
        && cinvGlobal_r == $past(storageAttrBits[0])) else $error("invalidate request wrong");
    chk_direct_nop: assert property (inv && mmuDirectStore && !mmuMiss && !mmuProtFault
        |=> !cinvValid_r && excCode_r == `SIU_EXC_NONE) else $error("direct store not ignored");
    chk_xlate_fault: assert property (inv && !mmuDirectStore && machineState[`SIU_MSR_DR] && mmuMiss
        |=> excCode_r == `SIU_EXC_DSI && !cinvValid_r) else $error("missing data access fault");
    chk_msr_read: assert property (isX && xo == `SIU_XO_MFMSR && sup
        |=> gprWe_r && gprData_r == $past(machineState)) else $error("state read wrong");
    chk_msr_write: assert property (isX && xo == `SIU_XO_MTMSR && sup |=> machineState == $past(sourceGpr)
        && ctxSync_r == |(($past(sourceGpr) ^ $past(machineState)) & ~`SIU_MSR_NOSYNC))
        else $error("state write wrong");
endmodule // siu_supervisor_props

bind siu_supervisor_unit siu_supervisor_props #(.VEC_BASE_LO(VEC_BASE_LO), .VEC_BASE_HI(VEC_BASE_HI)) chk_u (.*);
`default_nettype wire

// ===== tb/siu_supervisor_unit_tb_top.sv
// Self-checking bench for the supervisor instruction unit
`timescale 1ns/1ps
`default_nettype none
`include "siu_defs.vh"
module siu_supervisor_unit_tb_top;
    localparam [31:0] VLO = 32'h00000000;                 // Base, select low
    localparam [31:0] VHI = 32'hFFF00000;                 // Base, select high
    localparam [31:0] SCW = {`SIU_OP_SC, 24'h0, 2'b10};   // System call word
    localparam [31:0] RFW = {`SIU_OP_XL, 15'h0, `SIU_XO_RFI, 1'b0};
    // Design inputs and outputs
    logic        clk, rst_n, instrValid, extPending, mmuMiss, mmuProtFault, mmuDirectStore, regWr, regRd;
    logic [31:0] instrWord, instrPc, sourceGpr, baseGpr, indexGpr, regWdata;
    logic [2:0]  storageAttrBits;
    logic [3:0]  regAddr;
    wire         mmuIsStore, mmuSetChange, gprWe_r, redirValid_r, ctxSync_r, cinvValid_r, cinvGlobal_r;
    wire  [31:0] mmuAddr, gprData_r, redirAddr_r, cinvAddr_r, machineState, regRdata_r;
    wire  [4:0]  gprSel_r;
    wire  [2:0]  excCode_r;
    wire  [31:0] flags = {26'h0, excCode_r, ctxSync_r, gprWe_r, cinvValid_r}; // Pulses packed
    // Bench state
    integer      seed = 32'h9938;
    int          errorCnt = 0, numChecks = 0, k;
    logic [31:0] m, d, pc, old, cur, cpy, clr, ea, ix, seg [16];
    logic [4:0]  ra;
    logic [9:0]  pxo [9] = '{`SIU_XO_MFMSR, `SIU_XO_MTMSR, `SIU_XO_MFSPR, `SIU_XO_MTSPR, `SIU_XO_DCBI,
                             `SIU_XO_MTSR, `SIU_XO_MTSRIN, `SIU_XO_MFSR, `SIU_XO_MFSRIN};

    siu_supervisor_unit #(.VEC_BASE_LO(VLO), .VEC_BASE_HI(VHI)) dut_u (.*);

    // 25 MHz clock
    initial
    begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end

    // Mask from big-endian bit numbers
    function automatic [31:0] am(input int lo, input int hi);
        am = 32'h0;
        for (int i = lo; i <= hi; i++) am[31 - i] = 1'b1;
    endfunction
    function automatic [31:0] xf(input [9:0] x, input [4:0] t, input [4:0] a, input [4:0] b);
        xf = {`SIU_OP_X, t, a, b, x, 1'b0};
    endfunction
    // Special number halves go in swapped
    function automatic [31:0] sx(input [9:0] x, input [4:0] t, input [9:0] n);
        sx = xf(x, t, n[4:0], n[9:5]);
    endfunction
    function automatic [31:0] vb(input ip);
        vb = ip ? VHI : VLO;
    endfunction

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        numChecks++;
        if (got !== exp)
        begin
            errorCnt++;
            $display("CHECK FAILED at %0t: got %h want %h", $time, got, exp);
        end
    endtask
    // Context sync masked out where its value is open
    task automatic chkf(input [2:0] e, input w, input c);
        chk(flags & 32'h3B, {26'h0, e, 1'b0, w, c});
    endtask
    // One instruction, outputs settled on return
    task automatic exec(input logic [31:0] w, input logic [31:0] s, input logic [31:0] i);
        @(posedge clk);
        instrValid <= 1'b1;
        instrWord <= w;
        sourceGpr <= s;
        indexGpr <= i;
        @(posedge clk);
        instrValid <= 1'b0;
        #1;
    endtask
    task automatic setMsr(input logic [31:0] v);
        exec(xf(`SIU_XO_MTMSR, 5'h0, 5'h0, 5'h0), v, 32'h0);
    endtask
    task automatic rdReg(input logic [3:0] a, output logic [31:0] q);
        @(posedge clk);
        regRd <= 1'b1;
        regAddr <= a;
        @(posedge clk);
        regRd <= 1'b0;
        #1 q = regRdata_r;
    endtask
    task automatic wrReg(input logic [3:0] a, input logic [31:0] v);
        @(posedge clk);
        regWr <= 1'b1;
        regAddr <= a;
        regWdata <= v;
        @(posedge clk);
        regWr <= 1'b0;
    endtask
    task automatic giveVerdict;
        $display("checks %0d mismatches %0d", numChecks, errorCnt);
        if (errorCnt == 0 && numChecks > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask

    // Hang guard, far beyond the few hundred cycles needed
    initial
    begin
        repeat (5000) @(posedge clk);
        errorCnt++;
        giveVerdict;
    end

    // Main sequence
    initial
    begin
        {rst_n, instrValid, extPending, mmuMiss, mmuProtFault, mmuDirectStore, regWr, regRd} = 8'h00;
        {instrWord, instrPc, sourceGpr, baseGpr, indexGpr, regWdata} = 192'h0;
        storageAttrBits = 3'h0;
        regAddr = 4'h0;
        cpy = am(16, 23) | am(25, 27) | am(30, 31);
        clr = am(1, 4) | am(10, 15);
        repeat (8) @(posedge clk);
        #1 chk(machineState, `SIU_MSR_RST);
        rst_n <= 1'b1;
        rdReg(4'hF, d);
        chk(d, 32'h0);
        $display("reset test done");
        // State moves; only sleep and byte order changes skip the sync
        for (k = 0; k < 4; k++)
        begin
            m = $random(seed);
            m[`SIU_MSR_PR] = 1'b0;
            setMsr(m);
            chk(flags & 32'h4, 32'h4);
            exec(xf(`SIU_XO_MFMSR, 5'h3, 5'h0, 5'h0), 32'h0, 32'h0);
            chkf(`SIU_EXC_NONE, 1'b1, 1'b0);
            chk(gprData_r, m);
            chk({27'h0, gprSel_r}, 32'h3);
            rdReg(`SIU_REG_MSR, d);
            chk(d, m);
            setMsr(m ^ am(13, 13) ^ am(31, 31));
            chk(flags & 32'h4, 32'h0);
        end
        $display("state move test done");
        // Call then return: plain, pending interrupt, wide mode
        for (k = 0; k < 3; k++)
        begin
            m = $random(seed);
            m[`SIU_MSR_PR] = 1'b0;
            m[`SIU_MSR_EE] = 1'b1;
            setMsr(m);
            rdReg(`SIU_REG_SST, old);
            pc = $random(seed);
            instrPc <= pc;
            exec(SCW, 32'h0, 32'h0);
            chk(flags, {26'h0, `SIU_EXC_SC, 3'b100});
            chk(redirAddr_r, vb(m[`SIU_MSR_IP]) + `SIU_VEC_SC);
            chk({31'h0, redirValid_r}, 32'h1);
            rdReg(`SIU_REG_SPC, d);
            chk(d, pc + 32'h4);
            rdReg(`SIU_REG_SST, d);
            chk(d, (old & ~clr & ~cpy) | (m & cpy));
            cur = m & ~`SIU_MSR_EXCCLR;
            extPending <= (k == 1);
            if (k == 2)
            begin
                wrReg(`SIU_REG_CTL, 32'h1);
                rdReg(`SIU_REG_CTL, d);
                chk(d, 32'h1);
            end
            exec(RFW, 32'h0, 32'h0);
            chk(flags & 32'h4, 32'h4);
            if (k == 0)
            begin
                chk(redirAddr_r, (pc + 32'h4) & ~32'h3);
                chk(machineState, (cur & ~cpy) | (m & cpy));
            end
            else if (k == 1)
            begin
                chk(flags & 32'h38, {26'h0, `SIU_EXC_EXT, 3'h0});
                chk(redirAddr_r, vb(m[`SIU_MSR_IP]) + `SIU_VEC_EXT);
                rdReg(`SIU_REG_SPC, d);
                chk(d, (pc + 32'h4) & ~32'h3);
            end
            else
            begin
                chk(flags & 32'h38, {26'h0, `SIU_EXC_SYS, 3'h0});
                chk(redirAddr_r, vb(m[`SIU_MSR_IP]) + `SIU_VEC_SYS);
                wrReg(`SIU_REG_CTL, 32'h0);
            end
            extPending <= 1'b0;
        end
        $display("linkage test done");
        // Every supervisor op tried at user level
        for (k = 0; k < 10; k++)
        begin
            m = $random(seed);
            m[`SIU_MSR_PR] = 1'b1;
            setMsr(m);
            exec(k == 9 ? RFW : xf(pxo[k], 5'h3, 5'h4, 5'h5), m, 32'h0);
            chkf(`SIU_EXC_PROG, 1'b0, 1'b0);
            chk(redirAddr_r, vb(m[`SIU_MSR_IP]) + `SIU_VEC_PROG);
        end
        rdReg(`SIU_REG_STAT, d);
        chk(d, {29'h0, `SIU_EXC_PROG});
        $display("privilege test done");
        // Special moves; timebase halves written apart
        d = $random(seed);
        exec(sx(`SIU_XO_MTSPR, 5'h1, `SIU_SPR_SAVEPC), d, 32'h0);
        exec(sx(`SIU_XO_MFSPR, 5'h7, `SIU_SPR_SAVEPC), 32'h0, 32'h0);
        chk(gprData_r, d);
        m = $random(seed);
        exec(sx(`SIU_XO_MTSPR, 5'h1, `SIU_SPR_TBHI), m, 32'h0);
        exec(sx(`SIU_XO_MTSPR, 5'h1, `SIU_SPR_TBLO), 32'h0, 32'h0);
        exec(sx(`SIU_XO_MFSPR, 5'h2, `SIU_SPR_TBHI), 32'h0, 32'h0);
        chk(gprData_r, m);
        exec(sx(`SIU_XO_MFSPR, 5'h2, `SIU_SPR_TBLO), 32'h0, 32'h0);
        chk(gprData_r, 32'h3);
        $display("special move test done");
        // Segments written direct for even, indirect for odd; read the other way round, with translation on
        for (k = 0; k < 16; k++)
        begin
            seg[k] = $random(seed);
            d = $random(seed);
            exec(k[0] ? xf(`SIU_XO_MTSRIN, 5'h2, 5'h0, 5'h9) : xf(`SIU_XO_MTSR, 5'h2, {1'b0, k[3:0]}, 5'h0),
                seg[k], {k[3:0] ^ {4{~k[0]}}, d[27:0]});
        end
        setMsr(32'h00000030);
        for (k = 0; k < 16; k++)
        begin
            exec(k[0] ? xf(`SIU_XO_MFSR, 5'h6, {1'b0, k[3:0]}, 5'h0) : xf(`SIU_XO_MFSRIN, 5'h6, 5'h0, 5'h9),
                32'h0, {k[3:0] ^ {4{k[0]}}, 28'h0});
            chk(gprData_r, seg[k]);
        end
        $display("segment test done");
        // Block invalidate under random translation answers
        for (k = 0; k < 24; k++)
        begin
            d = $random(seed);
            m = $random(seed) & ~32'h00004000;
            setMsr(m);
            ix = $random(seed);
            ra = d[9] ? d[14:10] : 5'h0;
            baseGpr <= {d[31:15], d[14:0] ^ d[31:17]};
            ea = (ra == 5'h0 ? 32'h0 : {d[31:15], d[14:0] ^ d[31:17]}) + ix;
            mmuDirectStore <= d[0] & d[1];
            mmuMiss <= d[2] & ~(d[0] & d[1]);
            mmuProtFault <= d[3] & d[4] & ~(d[0] & d[1]);
            storageAttrBits <= d[7:5];
            exec(xf(`SIU_XO_DCBI, 5'h0, ra, 5'h2), 32'h0, ix);
            chk({31'h0, mmuSetChange}, 32'h0);
            if (d[0] & d[1])
                chkf(`SIU_EXC_NONE, 1'b0, 1'b0);
            else if ((m[`SIU_MSR_DR] & d[2]) | (d[3] & d[4]))
            begin
                chk(redirAddr_r, vb(m[`SIU_MSR_IP]) + `SIU_VEC_DSI);
                chkf(`SIU_EXC_DSI, 1'b0, 1'b0);
            end
            else
            begin
                chkf(`SIU_EXC_NONE, 1'b0, 1'b1);
                chk(cinvAddr_r, ea);
                chk({31'h0, cinvGlobal_r}, {31'h0, d[5]});
            end
        end
        $display("invalidate test done");
        giveVerdict;
    end
endmodule // siu_supervisor_unit_tb_top
`default_nettype wire
